/* hdl/mmr_decode_pkg.sv */
// Constants, carrier structs and the peripheral region table for the address decoder.
// Assumes one 250 MHz system clock shared by the core, the memories and the register blocks.
package mmr_decode_pkg;

  // ****************************************************************
  // Memory map
  // ****************************************************************
  localparam logic [31:0] FLASH_BASE       = 32'h0008_0000;
  localparam logic [31:0] SRAM_BASE        = 32'h0001_0000;
  localparam int          FLASH_BYTES      = 65536;
  localparam int          FLASH_USER_BYTES = 63488;
  localparam int          SRAM_BYTES       = 8192;
  localparam int          FLASH_PAGE_BYTES = 512;
  localparam logic [15:0] MMR_HI           = 16'hffff;
  localparam int          FLASH_WADDR_W    = $clog2(FLASH_BYTES / 2);
  localparam int          FLASH_PAGE_W     = $clog2(FLASH_BYTES / FLASH_PAGE_BYTES);
  localparam int          PAGE_LSB         = $clog2(FLASH_PAGE_BYTES / 2);
  localparam int          SRAM_WADDR_W     = $clog2(SRAM_BYTES / 4);
  localparam logic [FLASH_WADDR_W-1:0] KERNEL_WORD = FLASH_WADDR_W'(FLASH_USER_BYTES / 2);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ         = 250000;
  localparam int FLASH_THUMB_KHZ = 41780;
  localparam int FLASH_ARM_KHZ   = 20890;
  localparam int SRAM_KHZ        = 41780;
  localparam int CNT_W           = 4;
  localparam logic [CNT_W-1:0] FLASH_HALF_CYC =
    CNT_W'((CLK_KHZ + FLASH_THUMB_KHZ - 1) / FLASH_THUMB_KHZ);
  localparam logic [CNT_W:0]   FLASH_WORD_CYC =
    (CNT_W+1)'((CLK_KHZ + FLASH_ARM_KHZ - 1) / FLASH_ARM_KHZ);
  localparam logic [CNT_W-1:0] SRAM_CYC = CNT_W'((CLK_KHZ + SRAM_KHZ - 1) / SRAM_KHZ);
  localparam logic [CNT_W-1:0] AHB_CYC  = 4'h1;
  localparam logic [CNT_W-1:0] APB_CYC  = 4'h2;

  // ****************************************************************
  // Register space regions
  // ****************************************************************
  localparam int NUM_REGIONS = 19;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic        slow;
  } region_type;

  localparam region_type REGION_MAP [NUM_REGIONS] = '{
    '{16'h0000, 16'h0110, 1'b1},  // Interrupt controller
    '{16'h0220, 16'h0238, 1'b1},  // Remap and system control
    '{16'h0300, 16'h0310, 1'b1},  // Timer 0
    '{16'h0320, 16'h0334, 1'b1},  // General purpose timer
    '{16'h0340, 16'h0350, 1'b1},  // Wake-up timer
    '{16'h0360, 16'h0370, 1'b1},  // Watchdog timer
    '{16'h0404, 16'h0420, 1'b1},  // Clock control
    '{16'h0440, 16'h0448, 1'b1},  // Supply monitor
    '{16'h048c, 16'h0490, 1'b1},  // Reference
    '{16'h0500, 16'h0538, 1'b1},  // ADC
    '{16'h0600, 16'h0620, 1'b1},  // DAC
    '{16'h0700, 16'h0730, 1'b1},  // UART
    '{16'h0800, 16'h0850, 1'b1},  // Serial bus 0
    '{16'h0900, 16'h0950, 1'b1},  // Serial bus 1
    '{16'h0a00, 16'h0a14, 1'b1},  // SPI
    '{16'h0b00, 16'h0b54, 1'b1},  // Logic array
    '{16'hf400, 16'hf46c, 1'b0},  // GPIO
    '{16'hf800, 16'hf820, 1'b0},  // Flash control interface
    '{16'hfc00, 16'hfc3c, 1'b0}   // PWM
  };

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } size_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    size_type    size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } core_req_type;

  typedef struct packed {
    logic                   flash;
    logic                   sram;
    logic                   mmr;
    logic                   slow;
    logic [NUM_REGIONS-1:0] sel;
  } target_type;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FLASH = 6'b000010,
    ST_SRAM  = 6'b000100,
    ST_AHB   = 6'b001000,
    ST_APB   = 6'b010000,
    ST_DONE  = 6'b100000
  } state_type;

endpackage

/* hdl/mmr_region_decode.sv */
// Combinational address decoder: picks flash, SRAM or one register region.
// Assumes the caller registers the result; remap_i is 1 while flash sits at zero.
`timescale 1ns/1ns
`default_nettype none

module mmr_region_decode
  import mmr_decode_pkg::*;
(
  input  wire logic [31:0] addr_i,   // Byte address
  input  wire logic        remap_i,  // Flash mirrored at zero
  output target_type       tgt_o     // Decoded target
);

  logic [NUM_REGIONS-1:0] hit;
  logic [NUM_REGIONS-1:0] slow_hit;
  logic                   in_mmr;
  logic                   low_flash;
  logic                   low_sram;

  assign in_mmr    = addr_i[31:16] == MMR_HI;
  assign low_flash = addr_i < 32'(FLASH_BYTES);
  assign low_sram  = addr_i < 32'(SRAM_BYTES);

  // ****************************************************************
  // Region compare
  // ****************************************************************
  for (genvar i = 0; i < NUM_REGIONS; i++)
  begin : g_region
    assign hit[i] = in_mmr && addr_i[15:0] >= REGION_MAP[i].lo
                           && addr_i[15:0] <  REGION_MAP[i].hi;
    assign slow_hit[i] = hit[i] && REGION_MAP[i].slow;
  end

  always_comb
  begin
    tgt_o.flash = (addr_i >= FLASH_BASE && addr_i < FLASH_BASE + 32'(FLASH_BYTES))
               || (remap_i && low_flash);
    tgt_o.sram  = (addr_i >= SRAM_BASE && addr_i < SRAM_BASE + 32'(SRAM_BYTES))
               || (!remap_i && low_sram);
    tgt_o.sel   = hit;
    tgt_o.mmr   = |hit;
    tgt_o.slow  = |slow_hit;
  end

endmodule

`default_nettype wire

/* hdl/mmr_address_decoder.sv */
// Address decoder and access sequencer between the core and memories and register blocks.
// Assumes the core holds its request until done_o and the memories answer in fixed time.
`timescale 1ns/1ns
`default_nettype none

module mmr_address_decoder
  import mmr_decode_pkg::*;
(
  input  wire logic                     mclk_i,         // System clock
  input  wire logic                     rst_i,          // Synchronous reset
  input  wire core_req_type             req_i,          // Core request, held until done
  output logic                          done_o,         // Access complete pulse
  output logic                          unmapped_o,     // Completed access hit no target
  output logic [31:0]                   rdata_o,        // Read data
  input  wire logic                     remap_wr_i,     // Remap register write strobe
  input  wire logic                     remap_bit_i,    // Remap bit 0 written value
  output logic                          remap_o,        // Flash mirrored at zero
  output logic                          flash_req_o,    // Flash access level
  output logic [FLASH_WADDR_W-1:0]      flash_addr_o,   // Flash halfword address
  output logic [FLASH_PAGE_W-1:0]       flash_page_o,   // Flash page number
  output logic                          flash_kernel_o, // Access in kernel area
  input  wire logic [15:0]              flash_rdata_i,  // Flash read data
  output logic                          sram_req_o,     // SRAM access level
  output logic                          sram_we_o,      // SRAM write
  output logic [SRAM_WADDR_W-1:0]       sram_addr_o,    // SRAM word address
  output logic [3:0]                    sram_be_o,      // SRAM byte enables
  output logic [31:0]                   sram_wdata_o,   // SRAM write data
  input  wire logic [31:0]              sram_rdata_i,   // SRAM read data
  output logic                          ahb_stb_o,      // Fast bus strobe
  output logic                          apb_stb_o,      // Peripheral bus strobe
  output logic [NUM_REGIONS-1:0]        mmr_sel_o,      // Region select, one-hot
  output logic [15:0]                   mmr_addr_o,     // Register offset
  output logic                          mmr_we_o,       // Register write
  output logic [3:0]                    mmr_be_o,       // Register byte enables
  output logic [31:0]                   mmr_wdata_o,    // Register write data
  input  wire logic [31:0]              mmr_rdata_i     // Register read data
);

  typedef struct packed {
    state_type    st;
    logic [CNT_W-1:0] cnt;
    logic         half;
    logic         remap;
    logic         write;
    size_type     size;
    logic [31:0]  addr;
    logic [31:0]  wdata;
    target_type   tgt;
    logic [31:0]  rdata;
    logic         unmapped;
  } ctl_type;

  ctl_type    q;
  ctl_type    d;
  target_type dec;
  logic [3:0] be;
  logic       last;

  // ****************************************************************
  // Decode and byte lanes
  // ****************************************************************
  mmr_region_decode u_decode (
    .addr_i  (req_i.addr),
    .remap_i (q.remap),
    .tgt_o   (dec)
  );

  function automatic logic [3:0] lanes(input size_type sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    unique case (sz)
      SIZE_BYTE: m = 4'h1 << a;
      SIZE_HALF: m = a[1] ? 4'hc : 4'h3;
      SIZE_WORD: m = 4'hf;
      default:   m = 4'h0;
    endcase
    return m;
  endfunction

  assign be   = lanes(q.size, q.addr[1:0]);
  assign last = q.cnt == CNT_W'(1);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    d = q;
    if (remap_wr_i)
    begin
      d.remap = remap_bit_i;
    end
    unique case (q.st)
      ST_IDLE:
      begin
        if (req_i.valid)
        begin
          d.write    = req_i.write;
          d.size     = req_i.size;
          d.addr     = req_i.addr;
          d.wdata    = req_i.wdata;
          d.tgt      = dec;
          d.half     = 1'b0;
          d.unmapped = 1'b0;
          if (dec.flash)
          begin
            d.st  = ST_FLASH;
            d.cnt = FLASH_HALF_CYC;
          end
          else if (dec.sram)
          begin
            d.st  = ST_SRAM;
            d.cnt = SRAM_CYC;
          end
          else if (dec.mmr && dec.slow)
          begin
            d.st  = ST_APB;
            d.cnt = APB_CYC;
          end
          else if (dec.mmr)
          begin
            d.st  = ST_AHB;
            d.cnt = AHB_CYC;
          end
          else
          begin
            d.st       = ST_DONE;
            d.unmapped = 1'b1;
            d.rdata    = 32'h0000_0000;
          end
        end
      end
      ST_FLASH:
      begin
        d.cnt = q.cnt - CNT_W'(1);
        if (last)
        begin
          if (q.size != SIZE_WORD)
          begin
            d.rdata = {flash_rdata_i, flash_rdata_i};
            d.st    = ST_DONE;
          end
          else if (!q.half)
          begin
            d.rdata[15:0] = flash_rdata_i;
            d.half        = 1'b1;
            d.cnt         = FLASH_HALF_CYC;
          end
          else
          begin
            d.rdata[31:16] = flash_rdata_i;
            d.st           = ST_DONE;
          end
        end
      end
      ST_SRAM, ST_AHB, ST_APB:
      begin
        d.cnt = q.cnt - CNT_W'(1);
        if (last)
        begin
          d.rdata = (q.st == ST_SRAM) ? sram_rdata_i : mmr_rdata_i;
          d.st    = ST_DONE;
        end
      end
      ST_DONE:
      begin
        d.st = ST_IDLE;
      end
    endcase
    if (rst_i)
    begin
      d       = '0;
      d.st    = ST_IDLE;
      d.remap = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign done_o         = q.st == ST_DONE;
  assign unmapped_o     = q.unmapped;
  assign rdata_o        = q.rdata;
  assign remap_o        = q.remap;
  assign flash_req_o    = q.st == ST_FLASH;
  assign flash_addr_o   = {q.addr[FLASH_WADDR_W:2], q.addr[1] | q.half};
  assign flash_page_o   = flash_addr_o[FLASH_WADDR_W-1:PAGE_LSB];
  assign flash_kernel_o = flash_addr_o >= KERNEL_WORD;
  assign sram_req_o     = q.st == ST_SRAM;
  assign sram_we_o      = sram_req_o && q.write;
  assign sram_addr_o    = q.addr[SRAM_WADDR_W+1:2];
  assign sram_be_o      = be;
  assign sram_wdata_o   = q.wdata;
  assign ahb_stb_o      = q.st == ST_AHB;
  assign apb_stb_o      = q.st == ST_APB;
  assign mmr_sel_o      = (ahb_stb_o || apb_stb_o) ? q.tgt.sel : '0;
  assign mmr_addr_o     = q.addr[15:0];
  assign mmr_we_o       = (ahb_stb_o || apb_stb_o) && q.write;
  assign mmr_be_o       = be;
  assign mmr_wdata_o    = q.wdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  localparam logic [NUM_REGIONS-1:0] FAST_MASK = 19'h70000;

  property p_flash_two_halves;
    flash_req_o && q.size == SIZE_WORD && !q.half && last
      |=> flash_req_o && q.half && flash_addr_o[0] ##6 done_o;
  endproperty
  a_flash_two_halves: assert property (p_flash_two_halves)
    else $error("word flash access did not take a second halfword");

  property p_kernel_area;
    flash_req_o |-> flash_kernel_o == (flash_addr_o >= 15'h7c00);
  endproperty
  a_kernel_area: assert property (p_kernel_area)
    else $error("kernel area flag wrong");

  property p_page;
    flash_req_o |-> flash_page_o == flash_addr_o[14:8];
  endproperty
  a_page: assert property (p_page)
    else $error("flash page number wrong");

  property p_flash_pace;
    $rose(flash_req_o) |-> flash_req_o[*6];
  endproperty
  a_flash_pace: assert property (p_flash_pace)
    else $error("flash halfword access shorter than six cycles");

  property p_sram_pace;
    $rose(sram_req_o) |-> sram_req_o[*6] ##1 done_o;
  endproperty
  a_sram_pace: assert property (p_sram_pace)
    else $error("sram access not six cycles");

  property p_mmr_top;
    (ahb_stb_o || apb_stb_o) |-> q.addr[31:16] == 16'hffff;
  endproperty
  a_mmr_top: assert property (p_mmr_top)
    else $error("register strobe outside top pages");

  property p_ahb_one;
    $rose(ahb_stb_o) |=> !ahb_stb_o && done_o;
  endproperty
  a_ahb_one: assert property (p_ahb_one)
    else $error("fast bus access not one cycle");

  property p_apb_two;
    $rose(apb_stb_o) |-> apb_stb_o[*2] ##1 done_o;
  endproperty
  a_apb_two: assert property (p_apb_two)
    else $error("peripheral bus access not two cycles");

  property p_fast_route;
    (apb_stb_o |-> (mmr_sel_o & FAST_MASK) == '0)
      and (ahb_stb_o |-> (mmr_sel_o & ~FAST_MASK) == '0);
  endproperty
  a_fast_route: assert property (p_fast_route)
    else $error("region routed to wrong bus");

  property p_little_endian;
    sram_req_o && q.size == SIZE_BYTE |-> sram_be_o == (4'h1 << q.addr[1:0]);
  endproperty
  a_little_endian: assert property (p_little_endian)
    else $error("byte lane does not follow address");

  property p_remap_zero;
    q.st == ST_IDLE && req_i.valid && req_i.addr < 32'h0000_2000
      |=> (q.st == ST_FLASH) == $past(q.remap);
  endproperty
  a_remap_zero: assert property (p_remap_zero)
    else $error("address zero mapped to wrong memory");

  property p_onehot_sel;
    $onehot0(mmr_sel_o) && !(done_o && unmapped_o && q.tgt.mmr);
  endproperty
  a_onehot_sel: assert property (p_onehot_sel)
    else $error("more than one region selected");

  c_flash_word: cover property ($rose(flash_req_o) && q.size == SIZE_WORD);
  c_apb:        cover property ($rose(apb_stb_o));
  c_unmapped:   cover property (done_o && unmapped_o);
  c_remap_off:  cover property ($fell(q.remap));

endmodule

`default_nettype wire

/* bench/mem_partner.sv */
// Far side model: 16-bit flash, 32-bit SRAM and register blocks behind the decoder.
// Assumes the decoder's 250 MHz clock; no reset, flash and registers read fixed patterns, SRAM starts from an address-derived pattern and takes writes.
`timescale 1ns/1ns
`default_nettype none

module mem_partner
  import mmr_decode_pkg::*;
(
  input  wire logic                     mclk_i,        // System clock
  input  wire logic                     flash_req_i,   // Flash access level
  input  wire logic [FLASH_WADDR_W-1:0] flash_addr_i,  // Flash halfword address
  output logic [15:0]                   flash_rdata_o, // Flash read data
  input  wire logic                     sram_req_i,    // SRAM access level
  input  wire logic                     sram_we_i,     // SRAM write
  input  wire logic [SRAM_WADDR_W-1:0]  sram_addr_i,   // SRAM word address
  input  wire logic [3:0]               sram_be_i,     // SRAM byte enables
  input  wire logic [31:0]              sram_wdata_i,  // SRAM write data
  output logic [31:0]                   sram_rdata_o,  // SRAM read data
  input  wire logic                     ahb_stb_i,     // Fast bus strobe
  input  wire logic                     apb_stb_i,     // Peripheral bus strobe
  input  wire logic [15:0]              mmr_addr_i,    // Register offset
  output logic [31:0]                   mmr_rdata_o    // Register read data
);
  logic [31:0] mem [1 << SRAM_WADDR_W];

  function automatic logic [15:0] fdat(input logic [FLASH_WADDR_W-1:0] w);
    return {w, 1'b1} ^ 16'h5a3c;
  endfunction

  initial
  begin
    for (int i = 0; i < (1 << SRAM_WADDR_W); i++)
      mem[i] = 32'(i) ^ 32'hc3a5_0f1e;
  end

  // ****************************************************************
  // Memories: unselected lines show the inverse, never a held value
  // ****************************************************************
  assign flash_rdata_o = flash_req_i ? fdat(flash_addr_i) : ~fdat(flash_addr_i);
  assign sram_rdata_o  = sram_req_i ? mem[sram_addr_i] : ~mem[sram_addr_i];

  always @(posedge mclk_i)
  begin
    if (sram_req_i && sram_we_i)
      for (int k = 0; k < 4; k++)
        if (sram_be_i[k])
          mem[sram_addr_i][8*k +: 8] <= sram_wdata_i[8*k +: 8];
  end

  assign mmr_rdata_o = (ahb_stb_i || apb_stb_i) ? {mmr_addr_i ^ 16'h5a5a, mmr_addr_i}
                                                : {mmr_addr_i, ~mmr_addr_i};
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the address decoder with a behavioural map model.
// Assumes mem_partner answers flash, SRAM and register accesses.
`timescale 1ns/1ns
`default_nettype none

module tb import mmr_decode_pkg::*;;
  logic                     mclk_i, rst_i, remap_wr_i, remap_bit_i, remap_o;
  core_req_type             req_i;
  logic                     done_o, unmapped_o, flash_req_o, flash_kernel_o;
  logic                     sram_req_o, sram_we_o, ahb_stb_o, apb_stb_o, mmr_we_o;
  logic [31:0]              rdata_o, sram_wdata_o, sram_rdata_i, mmr_wdata_o, mmr_rdata_i;
  logic [FLASH_WADDR_W-1:0] flash_addr_o, fa0, fa1;
  logic [FLASH_PAGE_W-1:0]  flash_page_o, pg0;
  logic [15:0]              flash_rdata_i, mmr_addr_o, mad;
  logic [SRAM_WADDR_W-1:0]  sram_addr_o;
  logic [3:0]               sram_be_o, mmr_be_o, be_seen, mbe;
  logic [NUM_REGIONS-1:0]   mmr_sel_o, sel_seen;
  logic [31:0]              got_rd, mwd;
  logic [31:0]              sm [int];
  logic                     got_un, kn0, remap_m, mwe;
  int                       failures, checked, n_cyc, n_fl, n_sr, n_fast, n_slow, hole;

  localparam logic [31:0] FL_OFF [6] = '{32'h0, 32'h1fc, 32'h200, 32'hf7fc, 32'hf800, 32'hfffc};
  localparam logic [31:0] HOLES [4]  = '{32'h8000_0000, 32'hffff_fffc, 32'h0009_0000,
                                         32'hfffe_fffc};

  mmr_address_decoder i_mmr_address_decoder (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .done_o(done_o), .unmapped_o(unmapped_o), .rdata_o(rdata_o), .remap_wr_i(remap_wr_i),
    .remap_bit_i(remap_bit_i), .remap_o(remap_o), .flash_req_o(flash_req_o),
    .flash_addr_o(flash_addr_o), .flash_page_o(flash_page_o), .flash_kernel_o(flash_kernel_o),
    .flash_rdata_i(flash_rdata_i), .sram_req_o(sram_req_o), .sram_we_o(sram_we_o),
    .sram_addr_o(sram_addr_o), .sram_be_o(sram_be_o), .sram_wdata_o(sram_wdata_o),
    .sram_rdata_i(sram_rdata_i), .ahb_stb_o(ahb_stb_o), .apb_stb_o(apb_stb_o),
    .mmr_sel_o(mmr_sel_o), .mmr_addr_o(mmr_addr_o), .mmr_we_o(mmr_we_o), .mmr_be_o(mmr_be_o),
    .mmr_wdata_o(mmr_wdata_o), .mmr_rdata_i(mmr_rdata_i));

  mem_partner i_mem (.mclk_i(mclk_i), .flash_req_i(flash_req_o), .flash_addr_i(flash_addr_o),
    .flash_rdata_o(flash_rdata_i), .sram_req_i(sram_req_o), .sram_we_i(sram_we_o),
    .sram_addr_i(sram_addr_o), .sram_be_i(sram_be_o), .sram_wdata_i(sram_wdata_o),
    .sram_rdata_o(sram_rdata_i), .ahb_stb_i(ahb_stb_o), .apb_stb_i(apb_stb_o),
    .mmr_addr_i(mmr_addr_o), .mmr_rdata_o(mmr_rdata_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic acc(input logic w, input size_type sz, input logic [31:0] a, input logic [31:0] wd);
    req_i = '{1'b1, w, sz, a, wd};
    {n_cyc, n_fl, n_sr, n_fast, n_slow, hole} = '0;
    sel_seen = '0;
    do
    begin
      @(negedge mclk_i);
      n_cyc++;
      if (flash_req_o)
      begin
        if (n_fl == 0)
          {fa0, pg0, kn0} = {flash_addr_o, flash_page_o, flash_kernel_o};
        fa1 = flash_addr_o;
        n_fl++;
      end
      if (sram_req_o)
      begin
        n_sr++;
        be_seen = sram_be_o;
      end
      n_fast += int'(ahb_stb_o);
      n_slow += int'(apb_stb_o);
      if (ahb_stb_o || apb_stb_o)
        {sel_seen, mad, mwe, mbe, mwd} = {mmr_sel_o, mmr_addr_o, mmr_we_o, mmr_be_o, mmr_wdata_o};
      else if (mmr_sel_o !== '0)
        hole++;
    end while (done_o !== 1'b1 && n_cyc < 40);
    {got_rd, got_un} = {rdata_o, unmapped_o};
    req_i.valid = 1'b0;
    @(negedge mclk_i);
  endtask

  // One access with its expectation from the documented map
  task automatic run(input logic w, input size_type sz, input logic [31:0] a, input logic [31:0] wd);
    int k, idx, ec;
    logic slow;
    logic [31:0] off, er;
    logic [FLASH_WADDR_W-1:0] wa;
    logic [3:0] be;
    {k, idx, slow, off, er} = '0;
    if (a[31:16] == MMR_HI)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
        if (a[15:0] >= REGION_MAP[i].lo && a[15:0] < REGION_MAP[i].hi)
          {k, idx, slow} = {32'd3, 32'(i), REGION_MAP[i].slow};
    end
    else if (a >= FLASH_BASE && a < FLASH_BASE + FLASH_BYTES)
      {k, off} = {32'd1, a - FLASH_BASE};
    else if (a < 32'h0001_0000 && remap_m)
      {k, off} = {32'd1, a};
    else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES)
      {k, off} = {32'd2, a - SRAM_BASE};
    else if (a < SRAM_BYTES && !remap_m)
      {k, off} = {32'd2, a};
    be = sz == SIZE_BYTE ? 4'h1 << a[1:0] : sz == SIZE_HALF ? 4'h3 << {a[1], 1'b0} : 4'hf;
    wa = off[15:1];
    acc(w, sz, a, wd);
    ec = k == 0 ? 1 : k == 3 ? (slow ? 3 : 2) : (k == 1 && sz == SIZE_WORD) ? 13 : 7;
    chk("cycles", 32'(ec), 32'(n_cyc));
    chk("unmapped", 32'(k == 0), {31'h0, got_un});
    chk("fast strobe", 32'(k == 3 && !slow), 32'(n_fast));
    chk("slow strobe", (k == 3 && slow) ? 32'h2 : 32'h0, 32'(n_slow));
    chk("select", k == 3 ? 32'h1 << idx : 32'h0, 32'(sel_seen));
    chk("idle select", 32'h0, 32'(hole));
    case (k)
      1:
      begin
        chk("flash cycles", sz == SIZE_WORD ? 32'hc : 32'h6, 32'(n_fl));
        chk("flash first", 32'(wa), 32'(fa0));
        chk("flash last", 32'(wa + (sz == SIZE_WORD)), 32'(fa1));
        chk("flash page", 32'(wa[14:8]), 32'(pg0));
        chk("kernel", 32'(wa >= KERNEL_WORD), {31'h0, kn0});
        er = sz == SIZE_WORD ? {i_mem.fdat(wa + 1'b1), i_mem.fdat(wa)} : {2{i_mem.fdat(wa)}};
      end
      2:
      begin
        chk("sram cycles", 32'h6, 32'(n_sr));
        chk("sram lanes", 32'(be), 32'(be_seen));
        for (int j = 0; j < 4 && w; j++)
          if (be[j])
            sm[off[12:2]][8*j +: 8] = wd[8*j +: 8];
        er = w ? '0 : sm[off[12:2]];
      end
      3:
      begin
        chk("offset", 32'(a[15:0]), 32'(mad));
        chk("reg write", 32'(w), {31'h0, mwe});
        chk("reg lanes", 32'(be), 32'(mbe));
        if (w)
          chk("reg wdata", wd, mwd);
        er = {a[15:0] ^ 16'h5a5a, a[15:0]};
      end
      default: er = '0;
    endcase
    if (!w)
      chk("rdata", er, got_rd);
  endtask

  task automatic set_remap(input logic b);
    {remap_wr_i, remap_bit_i} = {1'b1, b};
    @(negedge mclk_i);
    remap_wr_i = 1'b0;
    remap_m = b;
    @(negedge mclk_i);
    chk("remap", 32'(b), {31'h0, remap_o});
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    req_i = '0;
    {rst_i, remap_wr_i, remap_bit_i, remap_m} = {1'b1, 1'b0, 1'b0, 1'b1};
    {failures, checked} = '0;
    void'($urandom(57));
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    chk("reset remap", 32'h1, {31'h0, remap_o});
    chk("reset done", 32'h0, {31'h0, done_o});
    $display("test reset done");
    for (int s = 0; s < 3; s++)
      for (int i = 0; i < 6; i++)
        run(0, size_type'(s), FLASH_BASE + FL_OFF[i], 32'h0);
    repeat (8) run(0, size_type'($urandom % 3), FLASH_BASE + ($urandom % 16384) * 4, 0);
    run(0, SIZE_WORD, 32'h0000_0004, 32'h0);
    $display("test flash done");
    run(1, SIZE_WORD, SRAM_BASE, 32'h0);
    for (int j = 0; j < 4; j++)
      run(1, SIZE_BYTE, SRAM_BASE + j, {4{8'(8'h11 * (j + 1))}});
    run(0, SIZE_WORD, SRAM_BASE, 32'h0);
    run(1, SIZE_HALF, SRAM_BASE + 2, {2{16'hbeef}});
    run(0, SIZE_BYTE, SRAM_BASE + 3, 32'h0);
    repeat (6)
    begin
      automatic logic [31:0] ra = SRAM_BASE + ($urandom % 2048) * 4;
      run(1, SIZE_WORD, ra, $urandom);
      run(0, SIZE_WORD, ra, 32'h0);
    end
    $display("test sram done");
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      run(0, SIZE_WORD, {MMR_HI, REGION_MAP[i].lo}, 32'h0);
      run(1, SIZE_WORD, {MMR_HI, REGION_MAP[i].hi - 16'h4}, $urandom);
      run(0, SIZE_WORD, {MMR_HI, REGION_MAP[i].hi}, 32'h0);
    end
    for (int i = 0; i < 4; i++)
      run(0, SIZE_WORD, HOLES[i], 32'h0);
    run(0, SIZE_WORD, SRAM_BASE + SRAM_BYTES, 32'h0);
    $display("test register space done");
    set_remap(1'b0);
    run(1, SIZE_WORD, 32'h0000_0010, $urandom);
    run(0, SIZE_WORD, SRAM_BASE + 32'h10, 32'h0);
    run(0, SIZE_WORD, 32'h0000_2000, 32'h0);
    set_remap(1'b1);
    run(0, SIZE_WORD, 32'h0000_0010, 32'h0);
    $display("test remap done");
    wrap_up;
  end

  initial
  begin
    repeat (30000) @(posedge mclk_i);
    failures++;
    $display("BAD watchdog exp done got hang");
    wrap_up;
  end
endmodule
`default_nettype wire
